// >>> core/smr_mode_regs.sv
// Overview of operation
// - read latency from A2 and A4-A6, whole cycles
// - first read data at posted plus read latency
// - loop reset bit clears itself after use
// - slow exit freezes loop in power-down
// - loop off in self-refresh, back on after
// - driver impedance from A1 and A5
// - write termination applied even without nominal
// - commands held for posted delay before issue
// - write latency from A3-A5, data at posted plus
// - output disable bit disconnects data and strobes
// - strobe-function bit swaps mask pin for strobes
// - no dynamic termination while write leveling
module smr_mode_regs
   import smr_pkg::*;
#(
   parameter int unsigned LOCK_CYCLES = LOCK_CYCLES_DEF,
   parameter int unsigned TRP_CYCLES  = TRP_CYCLES_DEF,
   parameter int unsigned DEPTH       = 32
)
(
   // clocks and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        linkClk,
   // command pins, link domain
   input  wire smr_cmd_t    cmdPins,
   input  wire logic        cke,
   // accepted commands and power states, core domain
   input  wire logic        cmdValid,
   input  wire logic        cmdWrite,
   input  wire logic        selfRefreshActive,
   input  wire logic        powerDownActive,
   // decoded settings
   output smr_fields_t      fields_ff,
   output logic [5:0]       apDelay_ff,
   // command timing
   output logic             rdIssue_ff,
   output logic             wrIssue_ff,
   output logic             rdDataStart_ff,
   output logic             wrDataStart_ff,
   // delay-locked loop
   output logic             dllRunning_ff,
   output logic             dllLocked_ff,
   output logic             dllResetBit_ff,
   output logic             dllResetPulse_ff,
   // pad control
   output logic             dataOutDisable_ff,
   output logic             maskEnable_ff,
   output logic             auxStrobeEnable_ff,
   output logic             termWriteSel_ff
);

   logic [15:0] linkMr0;
   logic [15:0] linkMr1;
   logic [15:0] linkMr2;
   logic [2:0]  linkSel;
   logic        linkToggle;
   logic [1:0]  togSync_ff;
   logic        togSeen_ff;
   logic        newUpd;
   logic [15:0] mr0Core_ff;
   logic [15:0] mr1Core_ff;
   logic [15:0] mr2Core_ff;
   logic [1:0]  pipe_ff [DEPTH];
   logic [1:0]  issueTap;
   logic [1:0]  readTap;
   logic [1:0]  writeTap;
   smr_dll_t    dllState_ff;
   smr_dll_t    nxt_dllState;
   logic [15:0] lockCnt_ff;
   logic        dllHalt;
   logic [2:0]  winCnt_ff;

   // -------------------------------------------------------------------
   // link-side capture
   // -------------------------------------------------------------------
   smr_link_capture u_capture (
      .linkClk      (linkClk),
      .sys_rst      (sys_rst),
      .cmdPins      (cmdPins),
      .cke          (cke),
      .mr0_ff       (linkMr0),
      .mr1_ff       (linkMr1),
      .mr2_ff       (linkMr2),
      .lastSel_ff   (linkSel),
      .updToggle_ff (linkToggle)
   );

   // -------------------------------------------------------------------
   // update crossing
   // -------------------------------------------------------------------
   // words are stable once the toggle has passed two flops
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         togSync_ff <= 2'h0;
         togSeen_ff <= 1'b0;
      end
      else
      begin
         togSync_ff <= {togSync_ff[0], linkToggle};
         togSeen_ff <= togSync_ff[1];
      end
   end

   assign newUpd = togSync_ff[1] ^ togSeen_ff;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         mr0Core_ff <= MR_RESET;
         mr1Core_ff <= MR_RESET;
         mr2Core_ff <= MR_RESET;
      end
      else if (newUpd)
      begin
         mr0Core_ff <= linkMr0;
         mr1Core_ff <= linkMr1;
         mr2Core_ff <= linkMr2;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         fields_ff <= smr_decode(MR_RESET, MR_RESET, MR_RESET);
      else
         fields_ff <= smr_decode(mr0Core_ff, mr1Core_ff, mr2Core_ff);
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         apDelay_ff <= 6'h00;
      else
         apDelay_ff <= 6'(fields_ff.writeRecovery) + 6'(TRP_CYCLES);
   end

   // -------------------------------------------------------------------
   // posted command delay line
   // -------------------------------------------------------------------
   function automatic logic [1:0] tapAt(input [4:0] d, input [1:0] cur, input [1:0] p [DEPTH]);
      return (d == 5'h00) ? cur : p[d - 5'h01];
   endfunction : tapAt

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < DEPTH; i++)
            pipe_ff[i] <= 2'h0;
      end
      else
      begin
         pipe_ff[0] <= {cmdValid, cmdWrite};
         for (int i = 1; i < DEPTH; i++)
            pipe_ff[i] <= pipe_ff[i-1];
      end
   end

   assign issueTap = tapAt(fields_ff.postedDelay, {cmdValid, cmdWrite}, pipe_ff);
   assign readTap  = tapAt(fields_ff.totalRead, {cmdValid, cmdWrite}, pipe_ff);
   assign writeTap = tapAt(fields_ff.totalWrite, {cmdValid, cmdWrite}, pipe_ff);

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         rdIssue_ff     <= 1'b0;
         wrIssue_ff     <= 1'b0;
         rdDataStart_ff <= 1'b0;
         wrDataStart_ff <= 1'b0;
      end
      else
      begin
         rdIssue_ff     <= issueTap[1] & ~issueTap[0];
         wrIssue_ff     <= issueTap[1] &  issueTap[0];
         rdDataStart_ff <= readTap[1]  & ~readTap[0];
         wrDataStart_ff <= writeTap[1] &  writeTap[0];
      end
   end

   // -------------------------------------------------------------------
   // loop reset, self-clearing
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         dllResetBit_ff   <= 1'b0;
         dllResetPulse_ff <= 1'b0;
      end
      else
      begin
         dllResetPulse_ff <= dllResetBit_ff;
         if (newUpd && linkSel == BA_LATENCY_RECOVERY && linkMr0[LOOP_RST_BIT])
            dllResetBit_ff <= 1'b1;
         else
            dllResetBit_ff <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // loop state
   // -------------------------------------------------------------------
   assign dllHalt = ~fields_ff.dllEnable | selfRefreshActive
                  | (powerDownActive & ~fields_ff.fastExit);

   always_comb
   begin
      nxt_dllState = dllState_ff;
      unique case (dllState_ff)
         DLL_HALTED:
            if (!dllHalt)
               nxt_dllState = DLL_LOCKING;
         DLL_LOCKING:
            if (dllHalt)
               nxt_dllState = DLL_HALTED;
            else if (lockCnt_ff == 16'(LOCK_CYCLES - 1))
               nxt_dllState = DLL_LOCKED;
         DLL_LOCKED:
            if (dllHalt)
               nxt_dllState = DLL_HALTED;
            else if (dllResetPulse_ff)
               nxt_dllState = DLL_LOCKING;
         default:
            nxt_dllState = DLL_HALTED;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         dllState_ff   <= DLL_HALTED;
         lockCnt_ff    <= 16'h0000;
         dllRunning_ff <= 1'b0;
         dllLocked_ff  <= 1'b0;
      end
      else
      begin
         dllState_ff   <= nxt_dllState;
         dllRunning_ff <= dllState_ff != DLL_HALTED;
         dllLocked_ff  <= dllState_ff == DLL_LOCKED;
         if (dllState_ff != DLL_LOCKING || dllResetPulse_ff)
            lockCnt_ff <= 16'h0000;
         else
            lockCnt_ff <= lockCnt_ff + 16'h0001;
      end
   end

   // -------------------------------------------------------------------
   // pad control
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         winCnt_ff <= 3'h0;
      else if (wrDataStart_ff)
         winCnt_ff <= BURST_CYCLES;
      else if (winCnt_ff != 3'h0)
         winCnt_ff <= winCnt_ff - 3'h1;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         dataOutDisable_ff  <= 1'b0;
         maskEnable_ff      <= 1'b1;
         auxStrobeEnable_ff <= 1'b0;
         termWriteSel_ff    <= 1'b0;
      end
      else
      begin
         dataOutDisable_ff  <= fields_ff.outputsOff;
         maskEnable_ff      <= ~fields_ff.termStrobe;
         auxStrobeEnable_ff <= fields_ff.termStrobe;
         termWriteSel_ff    <= (wrDataStart_ff || winCnt_ff != 3'h0)
                               && fields_ff.rttWr != 2'h0
                               && !fields_ff.writeLevel;
      end
   end

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence readCmdAt11;
      cmdValid && !cmdWrite && fields_ff.totalRead == 5'h0B;
   endsequence

   sequence writeCmdAt11;
      cmdValid && cmdWrite && fields_ff.totalWrite == 5'h0B;
   endsequence

   a_read_total: assert property (readCmdAt11 |-> ##12 rdDataStart_ff)
      else $error("read data start late or early");
   a_write_total: assert property (writeCmdAt11 |-> ##12 wrDataStart_ff)
      else $error("write data start late or early");
   a_issue_direct: assert property (
      cmdValid && !cmdWrite && fields_ff.postedDelay == 5'h00 |=> rdIssue_ff)
      else $error("undelayed read not issued");
   a_read_decode: assert property (
      mr0Core_ff[6:4] == 3'h1 && !mr0Core_ff[2] |=> fields_ff.readLatency == 5'h05)
      else $error("read latency decode wrong");
   a_loop_selfclr: assert property (
      $rose(dllResetBit_ff) |=> dllResetPulse_ff && !dllResetBit_ff)
      else $error("loop reset bit did not clear");
   a_loop_selfref: assert property (selfRefreshActive |=> ##1 !dllRunning_ff)
      else $error("loop running in self-refresh");
   a_loop_freeze: assert property (
      powerDownActive && !fields_ff.fastExit |=> ##1 !dllRunning_ff)
      else $error("loop not frozen in slow-exit power-down");
   a_out_disable: assert property (fields_ff.outputsOff |=> dataOutDisable_ff)
      else $error("outputs not disconnected");
   a_mask_strobe: assert property (maskEnable_ff != auxStrobeEnable_ff)
      else $error("mask and strobe function both active");
   a_wrterm_apply: assert property (
      wrDataStart_ff && fields_ff.rttWr != 2'h0 && !fields_ff.writeLevel |=> termWriteSel_ff)
      else $error("write termination not applied");
   a_wrlvl_nom: assert property (fields_ff.writeLevel |=> !termWriteSel_ff)
      else $error("dynamic termination during write leveling");
   a_drive_sel: assert property (
      $changed(mr1Core_ff) |=> fields_ff.driveSel == {$past(mr1Core_ff[5]), $past(mr1Core_ff[1])})
      else $error("driver impedance select wrong");

endmodule : smr_mode_regs

// >>> core/smr_pkg.sv
package smr_pkg;

   // -------------------------------------------------------------------
   // command decode
   // -------------------------------------------------------------------
   localparam logic [2:0]  BA_LATENCY_RECOVERY = 3'h0;
   localparam logic [2:0]  BA_DRIVE_TERM       = 3'h1;
   localparam logic [2:0]  BA_WRLAT_REFRESH    = 3'h2;
   localparam logic [15:0] MR_RESET            = 16'h0000;

   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int unsigned RLAT_LOW_BIT   = 2;
   localparam int unsigned RLAT_HI_LSB    = 4;
   localparam int unsigned TEST_MODE_BIT  = 7;
   localparam int unsigned LOOP_RST_BIT   = 8;
   localparam int unsigned WREC_LSB       = 9;
   localparam int unsigned PD_FAST_BIT    = 12;
   localparam int unsigned LOOP_DIS_BIT   = 0;
   localparam int unsigned DRV_LO_BIT     = 1;
   localparam int unsigned DRV_HI_BIT     = 5;
   localparam int unsigned NOM_B0_BIT     = 2;
   localparam int unsigned NOM_B1_BIT     = 6;
   localparam int unsigned NOM_B2_BIT     = 9;
   localparam int unsigned POSTED_LSB     = 3;
   localparam int unsigned WR_LEVEL_BIT   = 7;
   localparam int unsigned TERM_STRB_BIT  = 11;
   localparam int unsigned OUT_OFF_BIT    = 12;
   localparam int unsigned PASR_LSB       = 0;
   localparam int unsigned WLAT_LSB       = 3;
   localparam int unsigned AUTO_SR_BIT    = 6;
   localparam int unsigned EXT_TEMP_BIT   = 7;
   localparam int unsigned RTT_WR_LSB     = 9;

   // -------------------------------------------------------------------
   // timing counts
   // -------------------------------------------------------------------
   localparam int unsigned LOCK_CYCLES_DEF = 512;
   localparam int unsigned TRP_CYCLES_DEF  = 11;
   localparam logic [2:0]  BURST_CYCLES    = 3'h4;
   localparam logic [4:0]  RLAT_BASE       = 5'h04;
   localparam logic [4:0]  RLAT_HIGH_ADD   = 5'h08;
   localparam logic [4:0]  WLAT_BASE       = 5'h05;

   // -------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------
   typedef struct packed {
      logic        csN;
      logic        rasN;
      logic        casN;
      logic        weN;
      logic [2:0]  ba;
      logic [15:0] addr;
   } smr_cmd_t;

   typedef struct packed {
      logic [4:0] readLatency;
      logic [4:0] postedDelay;
      logic [4:0] writeLatency;
      logic [4:0] totalRead;
      logic [4:0] totalWrite;
      logic [4:0] writeRecovery;
      logic       fastExit;
      logic       dllEnable;
      logic       testMode;
      logic [1:0] driveSel;
      logic [2:0] rttNom;
      logic       writeLevel;
      logic       outputsOff;
      logic       termStrobe;
      logic [2:0] refreshArray;
      logic       autoSelfRefresh;
      logic       extendedTemp;
      logic [1:0] rttWr;
   } smr_fields_t;

   typedef enum logic [2:0] {
      DLL_HALTED  = 3'b001,
      DLL_LOCKING = 3'b010,
      DLL_LOCKED  = 3'b100
   } smr_dll_t;

   // -------------------------------------------------------------------
   // decoding
   // -------------------------------------------------------------------
   function automatic logic [4:0] smr_wrec(input logic [2:0] code);
      logic [4:0] v;
      v = 5'h10;
      unique case (code)
         3'h0: v = 5'h10;
         3'h1: v = 5'h05;
         3'h2: v = 5'h06;
         3'h3: v = 5'h07;
         3'h4: v = 5'h08;
         3'h5: v = 5'h0A;
         3'h6: v = 5'h0C;
         3'h7: v = 5'h0E;
      endcase
      return v;
   endfunction : smr_wrec

   function automatic smr_fields_t smr_decode(input logic [15:0] m0,
                                              input logic [15:0] m1,
                                              input logic [15:0] m2);
      smr_fields_t f;
      f = '0;
      f.readLatency  = RLAT_BASE + 5'(m0[RLAT_HI_LSB +: 3])
                     + (m0[RLAT_LOW_BIT] ? RLAT_HIGH_ADD : 5'h00);
      unique case (m1[POSTED_LSB +: 2])
         2'h1:    f.postedDelay = f.readLatency - 5'h01;
         2'h2:    f.postedDelay = f.readLatency - 5'h02;
         default: f.postedDelay = 5'h00;
      endcase
      f.writeLatency    = WLAT_BASE + 5'(m2[WLAT_LSB +: 3]);
      f.totalRead       = f.postedDelay + f.readLatency;
      f.totalWrite      = f.postedDelay + f.writeLatency;
      f.writeRecovery   = smr_wrec(m0[WREC_LSB +: 3]);
      f.fastExit        = m0[PD_FAST_BIT];
      f.dllEnable       = ~m1[LOOP_DIS_BIT];
      f.testMode        = m0[TEST_MODE_BIT];
      f.driveSel        = {m1[DRV_HI_BIT], m1[DRV_LO_BIT]};
      f.rttNom          = {m1[NOM_B2_BIT], m1[NOM_B1_BIT], m1[NOM_B0_BIT]};
      f.writeLevel      = m1[WR_LEVEL_BIT];
      f.outputsOff      = m1[OUT_OFF_BIT];
      f.termStrobe      = m1[TERM_STRB_BIT];
      f.refreshArray    = m2[PASR_LSB +: 3];
      f.autoSelfRefresh = m2[AUTO_SR_BIT];
      f.extendedTemp    = m2[EXT_TEMP_BIT];
      f.rttWr           = m2[RTT_WR_LSB +: 2];
      return f;
   endfunction : smr_decode

endpackage : smr_pkg

// >>> core/smr_link_capture.sv
module smr_link_capture
   import smr_pkg::*;
(
   // link side
   input  wire logic        linkClk,
   input  wire logic        sys_rst,
   input  wire smr_cmd_t    cmdPins,
   input  wire logic        cke,
   // captured words
   output logic [15:0]      mr0_ff,
   output logic [15:0]      mr1_ff,
   output logic [15:0]      mr2_ff,
   output logic [2:0]       lastSel_ff,
   output logic             updToggle_ff
);

   logic rstMeta_ff;
   logic rstLink_ff;
   logic modeSet;

   // -------------------------------------------------------------------
   // reset into the link domain
   // -------------------------------------------------------------------
   always_ff @(posedge linkClk) begin
      rstMeta_ff <= sys_rst;
      rstLink_ff <= rstMeta_ff;
   end

   // pins are sampled by the link clock itself
   assign modeSet = cke & ~cmdPins.csN & ~cmdPins.rasN & ~cmdPins.casN & ~cmdPins.weN;

   // -------------------------------------------------------------------
   // mode set capture
   // -------------------------------------------------------------------
   always_ff @(posedge linkClk)
   begin
      if (rstLink_ff)
      begin
         mr0_ff       <= MR_RESET;
         mr1_ff       <= MR_RESET;
         mr2_ff       <= MR_RESET;
         lastSel_ff   <= BA_LATENCY_RECOVERY;
         updToggle_ff <= 1'b0;
      end
      else if (modeSet && cmdPins.ba <= BA_WRLAT_REFRESH)
      begin
         unique case (cmdPins.ba)
            BA_LATENCY_RECOVERY: mr0_ff <= cmdPins.addr;
            BA_DRIVE_TERM:       mr1_ff <= cmdPins.addr;
            default:             mr2_ff <= cmdPins.addr;
         endcase
         lastSel_ff   <= cmdPins.ba;
         updToggle_ff <= ~updToggle_ff;
      end
   end

   a_mode_capture: assert property (@(posedge linkClk) disable iff (rstLink_ff)
      modeSet && cmdPins.ba == BA_DRIVE_TERM |=> mr1_ff == $past(cmdPins.addr)
                                               && updToggle_ff != $past(updToggle_ff))
      else $error("mode set not captured");

endmodule : smr_link_capture

// >>> verif/smr_ctrl_model.sv
module smr_ctrl_model
   import smr_pkg::*;
(
   // link side
   input  wire logic linkClk,
   output smr_cmd_t  cmdPins,
   output logic      cke
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      cmdPins = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h7, 16'hFFFF};
      cke = 1'b1;
   end

   // one mode set; deselect scrambles the bus afterwards
   task automatic mrs(input logic [2:0] ba, input logic [15:0] a, input logic ck);
      @(negedge linkClk);
      cke <= ck;
      cmdPins <= '{1'b0, 1'b0, 1'b0, 1'b0, ba, a};
      @(negedge linkClk);
      cmdPins <= '{1'b1, 1'b1, 1'b1, 1'b1, ~ba, ~a};
      cke <= 1'b1;
   endtask : mrs
endmodule : smr_ctrl_model

// >>> verif/smr_mode_regs_tb.sv
module smr_mode_regs_tb
   import smr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned LOCK = 8;
   logic        core_clk, sys_rst, linkClk, cmdValid, cmdWrite, srAct, pdAct, cke;
   logic        rdIss, wrIss, rdDat, wrDat, dllRun, dllLock, rstBit, rstPulse;
   logic        outOff, maskEn, auxEn, termWr, seen;
   logic [5:0]  apDelay;
   smr_fields_t f;
   smr_cmd_t    cmdPins;
   int          errTotal = 0;
   int          checks = 0;
   int          n;

   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial
   begin
      linkClk = 1'b0;
      #1.3;
      forever #7.5 linkClk = ~linkClk;
   end

   smr_mode_regs #(.LOCK_CYCLES(LOCK)) u_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .linkClk(linkClk), .cmdPins(cmdPins),
      .cke(cke), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .selfRefreshActive(srAct),
      .powerDownActive(pdAct), .fields_ff(f), .apDelay_ff(apDelay), .rdIssue_ff(rdIss),
      .wrIssue_ff(wrIss), .rdDataStart_ff(rdDat), .wrDataStart_ff(wrDat),
      .dllRunning_ff(dllRun), .dllLocked_ff(dllLock), .dllResetBit_ff(rstBit),
      .dllResetPulse_ff(rstPulse), .dataOutDisable_ff(outOff), .maskEnable_ff(maskEn),
      .auxStrobeEnable_ff(auxEn), .termWriteSel_ff(termWr));
   smr_ctrl_model u_ctrl (.linkClk(linkClk), .cmdPins(cmdPins), .cke(cke));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         errTotal++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk

   task automatic wt(input int k);
      repeat (k) @(negedge core_clk);
   endtask : wt

   // mode set, then room for the crossing and the spacing rule
   task automatic set(input logic [2:0] ba, input logic [15:0] a, input logic ck);
      u_ctrl.mrs(ba, a, ck);
      wt(24);
   endtask : set

   task automatic cmd(input logic wr, input logic [7:0] iss, input logic [7:0] dat,
                      input logic trm);
      int gi;
      int gd;
      gi = -1;
      gd = -1;
      @(negedge core_clk);
      cmdValid = 1'b1;
      cmdWrite = wr;
      @(negedge core_clk);
      cmdValid = 1'b0;
      for (int k = 1; k <= 40; k++)
      begin
         if ((wr ? wrIss : rdIss) === 1'b1 && gi < 0)
            gi = k;
         if (wr && gd >= 0 && k == gd + 1)
            chk(8'(termWr), 8'(trm));
         if ((wr ? wrDat : rdDat) === 1'b1 && gd < 0)
            gd = k;
         @(negedge core_clk);
      end
      chk(8'(gi), iss);
      chk(8'(gd), dat);
   endtask : cmd

   task automatic giveVerdict();
      $display("errors %0d checks %0d", errTotal, checks);
      if (errTotal == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : giveVerdict

   initial
   begin
      #100000;
      errTotal++;
      giveVerdict();
   end

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial
   begin
      sys_rst = 1'b1;
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      srAct = 1'b0;
      pdAct = 1'b0;
      wt(6);
      sys_rst = 1'b0;
      wt(16);
      chk(8'(f.readLatency), 8'h04);
      chk(8'(apDelay), 8'(16 + TRP_CYCLES_DEF));
      chk(8'(maskEn), 8'h01);
      cmd(1'b0, 8'h01, 8'h05, 1'b0);
      u_ctrl.mrs(3'h0, 16'h1320, 1'b1);
      seen = 1'b0;
      n = 0;
      while (rstPulse !== 1'b1 && n < 60)
      begin
         seen = seen | (rstBit === 1'b1);
         n++;
         @(negedge core_clk);
      end
      chk(8'(seen), 8'h01);
      chk(8'(rstBit), 8'h00);
      wt(2);
      chk(8'(dllLock), 8'h00);
      wt(LOCK + 4);
      chk(8'(dllLock), 8'h01);
      chk(8'(f.readLatency), 8'h06);
      chk(8'(apDelay), 8'(5 + TRP_CYCLES_DEF));
      set(3'h1, 16'h080A, 1'b1);
      chk(8'(f.postedDelay), 8'h05);
      chk(8'(f.totalRead), 8'h0B);
      chk(8'(f.driveSel), 8'h01);
      chk(8'({maskEn, auxEn}), 8'h01);
      set(3'h2, 16'h0208, 1'b1);
      chk(8'(f.writeLatency), 8'h06);
      cmd(1'b0, 8'h06, 8'h0C, 1'b0);
      cmd(1'b1, 8'h06, 8'h0C, 1'b1);
      set(3'h1, 16'h1000, 1'b0);
      set(3'h3, 16'h1000, 1'b1);
      chk(8'(outOff), 8'h00);
      set(3'h1, 16'h1088, 1'b1);
      chk(8'({outOff, maskEn}), 8'h03);
      cmd(1'b1, 8'h06, 8'h0C, 1'b0);
      srAct = 1'b1;
      wt(4);
      chk(8'(dllRun), 8'h00);
      srAct = 1'b0;
      wt(LOCK + 6);
      chk(8'({dllRun, dllLock}), 8'h03);
      pdAct = 1'b1;
      wt(4);
      chk(8'(dllRun), 8'h01);
      pdAct = 1'b0;
      set(3'h0, 16'h0210, 1'b1);
      chk(8'(f.readLatency), 8'h05);
      pdAct = 1'b1;
      wt(4);
      chk(8'(dllRun), 8'h00);
      pdAct = 1'b0;
      wt(4);
      giveVerdict();
   end
endmodule : smr_mode_regs_tb
